// >>> hdl/codec_ctrl_pkg.sv
package codec_ctrl_pkg;

  // clock ratio, initialisation, reset, slip, zero-run and crystal timing
  localparam int          CYC_256          = 256;
  localparam int          CYC_384          = 384;
  localparam int          CYC_512          = 512;
  localparam int          INIT_CYCLES      = 1024;
  localparam int          RESET_MIN_NS     = 40;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          RESET_MIN_CYC    =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SLIP_LOSS_BITS   = 6;
  localparam int          SLIP_OK_BITS     = 5;
  localparam int          ZERO_RUN_BITS    = 65536;
  localparam int          XTAL_IDLE_CYC    = 8;

  // control word fields
  localparam int          WORD_W           = 16;
  localparam int          ADDR_HI          = 10;
  localparam int          ADDR_LO          = 9;
  localparam int          LOAD_BIT         = 8;
  localparam int          ADC_POWER_DOWN_BIT         = 8;
  localparam int          BYPASS_BIT       = 7;
  localparam int          COMMON_BIT       = 5;
  localparam int          ZDET_BIT         = 4;
  localparam int          FORCE_BIT        = 3;
  localparam int          DEEM_HI          = 2;
  localparam int          DEEM_LO          = 1;
  localparam int          SILENCE_BIT      = 0;
  localparam int          LOOP_BIT         = 5;
  localparam int          FMT_HI           = 4;
  localparam int          FMT_LO           = 2;
  localparam int          POL_BIT          = 1;

  localparam logic [1:0]  ADDR_LEFT        = 2'h0;
  localparam logic [1:0]  ADDR_RIGHT       = 2'h1;
  localparam logic [1:0]  ADDR_FUNC        = 2'h2;
  localparam logic [1:0]  ADDR_FMT         = 2'h3;

  // reset values
  localparam logic [7:0]  LEVEL_RST        = 8'hFF;
  localparam logic [2:0]  FMT_RST          = 3'h0;
  localparam logic [1:0]  DEEM_RST         = 2'h0;

  typedef enum logic [1:0] {
    RATIO_256,
    RATIO_384,
    RATIO_512,
    RATIO_UNKNOWN
  } ratio_t;

  typedef enum logic [1:0] {
    DEEM_OFF,
    DEEM_48K,
    DEEM_44K1,
    DEEM_32K
  } deem_t;

  typedef struct packed {
    logic [7:0] left_level_code;
    logic [7:0] right_level_code;
    logic       adc_power_down;
    logic       hpf_bypass;
    logic       common_level_mode;
    logic       zero_detect_enable;
    logic       output_force;
    deem_t      deemphasis_select;
    logic       soft_silence_enable;
    logic       adc_to_dac_loopback;
    logic [2:0] audio_format_select;
    logic       frame_clock_polarity;
  } ctrl_t;

endpackage : codec_ctrl_pkg

// >>> hdl/control_port_rx.sv
`timescale 1ns/1ns
// three-wire control receiver; pins are sampled in the system clock domain
module control_port_rx
  import codec_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst_n,
  input  wire logic              control_shift_clock,
  input  wire logic              control_serial_data,
  input  wire logic              control_latch,
  output logic                   word_valid,
  output logic [WORD_W-1:0]      word_data
);

  logic              sck_q_r;
  logic              lat_q_r;
  logic [WORD_W-1:0] shift_r;

  always_ff @(posedge clk) begin
    if (!srst_n) begin
      sck_q_r <= 1'b0;
      lat_q_r <= 1'b0;
    end else begin
      sck_q_r <= control_shift_clock;
      lat_q_r <= control_latch;
    end
  end

  // msb first, one bit per shift-clock rising edge
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      shift_r <= '0;
    end else if (control_shift_clock && !sck_q_r) begin
      shift_r <= {shift_r[WORD_W-2:0], control_serial_data};
    end
  end

  // latch rising edge commits the last sixteen bits
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      word_valid <= 1'b0;
      word_data  <= '0;
    end else begin
      word_valid <= control_latch && !lat_q_r;
      if (control_latch && !lat_q_r) begin
        word_data <= shift_r;
      end
    end
  end

endmodule : control_port_rx

// >>> hdl/sysclk_ratio_detect.sv
`timescale 1ns/1ns
// counts system clocks per frame clock period and names the ratio
module sysclk_ratio_detect
  import codec_ctrl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  srst_n,
  input  wire logic  frame_clock_in,
  output ratio_t     ratio,
  output logic       frame_start
);

  logic        fc_q_r;
  logic [10:0] cnt_r;

  always_ff @(posedge clk) begin
    if (!srst_n) begin
      fc_q_r <= 1'b0;
    end else begin
      fc_q_r <= frame_clock_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!srst_n) begin
      cnt_r       <= '0;
      ratio       <= RATIO_UNKNOWN;
      frame_start <= 1'b0;
    end else begin
      frame_start <= frame_clock_in && !fc_q_r;
      if (frame_clock_in && !fc_q_r) begin
        cnt_r <= 11'h001;
        // a ratio is held only when the count matches exactly
        unique case (cnt_r)
          11'(CYC_256): ratio <= RATIO_256;
          11'(CYC_384): ratio <= RATIO_384;
          11'(CYC_512): ratio <= RATIO_512;
          default:      ratio <= RATIO_UNKNOWN;
        endcase
      end else if (cnt_r != 11'h7FF) begin
        cnt_r <= cnt_r + 11'h001;
      end
    end
  end

endmodule : sysclk_ratio_detect

// >>> hdl/codec_clock_reset_control.sv
`timescale 1ns/1ns
// What this block does
// - system clock is 256, 384 or 512 fs; ratio found without setup
// - 384 and 512 fs clocks are divided to a 256 fs enable
// - crystal clock present drives clock pin out; else pin is input
// - power-on start runs a 1024-cycle initialisation
// - initialisation starts at reset pin rise, lasts 1024 cycles
// - slip over 6 bit clocks stops dac, holds bipolar zero
// - same slip stops adc, output codes held at bipolar zero
// - slip of 5 bit clocks or less keeps normal operation
// - host configures functions through three-wire serial port
// - four 16-bit program registers
// - word bits 10 and 9 select the register
// - registers 0 and 1 hold load bit 8 and level code
// - register 2 holds converter function bits
// - register 3 holds loopback, format and polarity
// - format resets to 16-bit right/left-justified, format 0
// - polarity resets to high-is-left, loopback off
// - levels reset to 0 dB individual; detect, mute, deemph off
// - power-down off, high-pass active; three deemph curves
// - load bit clear stores code only; set applies both codes
// - zero input for 65536 bit clocks disconnects output amp
// - common mode applies register 0 code to both channels
// - deemphasis 00 off, 01 48k, 10 44.1k, 11 32k
module codec_clock_reset_control
  import codec_ctrl_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_BITS
)(
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  reset_n_pin,
  input  wire logic  crystal_in,
  input  wire logic  buffered_clock_pin_in,
  output logic       buffered_clock_pin_out,
  output logic       buffered_clock_pin_oe,
  input  wire logic  frame_clock_in,
  input  wire logic  bit_clock_in,
  input  wire logic  dac_input_zero,
  input  wire logic  control_shift_clock,
  input  wire logic  control_serial_data,
  input  wire logic  control_latch,
  output logic       clk256_en,
  output ratio_t     ratio_detected,
  output logic       init_busy,
  output logic       sync_lost,
  output logic       dac_force_zero,
  output logic       adc_force_zero,
  output logic       amp_disconnect,
  output logic [7:0] left_level_active,
  output logic [7:0] right_level_active,
  output ctrl_t      ctrl
);

  logic        rst_pin_q_r;
  logic        init_start;
  logic [10:0] init_cnt_r;
  logic        srst_n;
  ratio_t      ratio;
  logic        frame_start;
  logic        word_valid;
  logic [15:0] word_data;
  logic [1:0]  div_cnt_r;
  logic        xtal_q_r;
  logic [3:0]  xtal_idle_r;
  logic        bck_q_r;
  logic        bck_rise;
  logic [7:0]  slip_cnt_r;
  logic [7:0]  bits_ref_r;
  logic        ref_valid_r;
  logic [7:0]  slip;
  logic [16:0] zero_run_r;
  logic [7:0]  left_store_r;
  logic [7:0]  right_store_r;
  logic        load_req;

  assign srst_n = nrst && reset_n_pin;

  // the internal reset pin is sampled; its rise restarts initialisation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_pin_q_r <= 1'b0;
    end else begin
      rst_pin_q_r <= reset_n_pin;
    end
  end
  assign init_start = reset_n_pin && !rst_pin_q_r;

  // pin low for one 10 ns cycle already restarts init, though the 40 ns minimum is four cycles
  always_ff @(posedge clk) begin
    if (!nrst || !reset_n_pin) begin
      init_cnt_r <= '0;
      init_busy  <= 1'b1;
    end else if (init_start) begin
      init_cnt_r <= '0;
      init_busy  <= 1'b1;
    end else if (init_busy) begin
      init_cnt_r <= init_cnt_r + 11'h001;
      if (init_cnt_r == 11'(INIT_CYCLES - 1)) begin
        init_busy <= 1'b0;
      end
    end
  end

  sysclk_ratio_detect u_ratio (
    .clk            (clk),
    .srst_n         (srst_n),
    .frame_clock_in (frame_clock_in),
    .ratio          (ratio),
    .frame_start    (frame_start)
  );

  control_port_rx u_rx (
    .clk                 (clk),
    .srst_n              (srst_n),
    .control_shift_clock (control_shift_clock),
    .control_serial_data (control_serial_data),
    .control_latch       (control_latch),
    .word_valid          (word_valid),
    .word_data           (word_data)
  );

  always_ff @(posedge clk) begin
    if (!srst_n) begin
      ratio_detected <= RATIO_UNKNOWN;
    end else begin
      ratio_detected <= ratio;
    end
  end

  // 256 fs enable: every cycle, 2 of 3, or 1 of 2 system clocks
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      div_cnt_r <= '0;
      clk256_en <= 1'b0;
    end else if (frame_start) begin
      // realign per frame without dropping the pulse owed to this slot
      div_cnt_r <= '0;
      clk256_en <= (ratio == RATIO_256 || ratio == RATIO_512);
    end else begin
      unique case (ratio)
        RATIO_256: begin
          div_cnt_r <= '0;
          clk256_en <= 1'b1;
        end
        RATIO_384: begin
          div_cnt_r <= (div_cnt_r == 2'h2) ? 2'h0 : div_cnt_r + 2'h1;
          clk256_en <= (div_cnt_r != 2'h2);
        end
        RATIO_512: begin
          div_cnt_r <= div_cnt_r ^ 2'h1;
          clk256_en <= div_cnt_r[0];
        end
        RATIO_UNKNOWN: begin
          div_cnt_r <= '0;
          clk256_en <= 1'b0;
        end
      endcase
    end
  end

  // crystal activity: edges seen recently mean we drive the clock pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xtal_q_r              <= 1'b0;
      xtal_idle_r           <= 4'(XTAL_IDLE_CYC);
      buffered_clock_pin_oe <= 1'b0;
      buffered_clock_pin_out <= 1'b0;
    end else begin
      xtal_q_r <= crystal_in;
      if (crystal_in != xtal_q_r) begin
        xtal_idle_r <= '0;
      end else if (xtal_idle_r != 4'(XTAL_IDLE_CYC)) begin
        xtal_idle_r <= xtal_idle_r + 4'h1;
      end
      buffered_clock_pin_oe  <= (xtal_idle_r != 4'(XTAL_IDLE_CYC));
      buffered_clock_pin_out <= crystal_in;
    end
  end

  // bit clocks per frame compared with the first frame after reset, then with the frame that last lost sync
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      bck_q_r <= 1'b0;
    end else begin
      bck_q_r <= bit_clock_in;
    end
  end
  assign bck_rise = bit_clock_in && !bck_q_r;
  assign slip = (slip_cnt_r > bits_ref_r) ? slip_cnt_r - bits_ref_r
                                          : bits_ref_r - slip_cnt_r;

  // host keeps frame clock locked; a ratio loss also counts as slip
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      slip_cnt_r  <= '0;
      bits_ref_r  <= '0;
      ref_valid_r <= 1'b0;
      sync_lost   <= 1'b0;
    end else if (frame_start) begin
      slip_cnt_r <= '0;
      if (!ref_valid_r) begin
        bits_ref_r  <= slip_cnt_r;
        ref_valid_r <= 1'b1;
      end else if (slip > 8'(SLIP_LOSS_BITS) ||
                   ratio == RATIO_UNKNOWN) begin
        sync_lost  <= 1'b1;
        bits_ref_r <= slip_cnt_r;
      end else if (slip <= 8'(SLIP_OK_BITS)) begin
        sync_lost <= 1'b0;
      end
    end else if (bck_rise && slip_cnt_r != 8'hFF) begin
      slip_cnt_r <= slip_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!srst_n) begin
      dac_force_zero <= 1'b1;
      adc_force_zero <= 1'b1;
    end else begin
      dac_force_zero <= init_busy || sync_lost || ctrl.output_force;
      adc_force_zero <= init_busy || sync_lost || ctrl.adc_power_down;
    end
  end

  // count stops at the limit so the disconnect holds while zero persists
  always_ff @(posedge clk) begin
    if (!srst_n || !ctrl.zero_detect_enable || !dac_input_zero) begin
      zero_run_r     <= '0;
      amp_disconnect <= 1'b0;
    end else if (bck_rise) begin
      if (zero_run_r != 17'(ZERO_RUN)) begin
        zero_run_r <= zero_run_r + 17'h00001;
      end
      if (zero_run_r >= 17'(ZERO_RUN - 1)) begin
        amp_disconnect <= 1'b1;
      end
    end
  end

  assign load_req = word_valid && word_data[LOAD_BIT] &&
                    (word_data[ADDR_HI:ADDR_LO] == ADDR_LEFT ||
                     word_data[ADDR_HI:ADDR_LO] == ADDR_RIGHT);

  // reserved bits are dropped; the host is expected to send zero
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      left_store_r <= LEVEL_RST;
      right_store_r <= LEVEL_RST;
      ctrl <= '{left_level_code: LEVEL_RST, right_level_code: LEVEL_RST,
                deemphasis_select: DEEM_OFF, audio_format_select: FMT_RST,
                frame_clock_polarity: 1'b0,
                default: 1'b0};
    end else if (word_valid) begin
      unique case (word_data[ADDR_HI:ADDR_LO])
        ADDR_LEFT: begin
          left_store_r         <= word_data[7:0];
          ctrl.left_level_code <= word_data[7:0];
        end
        ADDR_RIGHT: begin
          right_store_r         <= word_data[7:0];
          ctrl.right_level_code <= word_data[7:0];
        end
        ADDR_FUNC: begin
          ctrl.adc_power_down      <= word_data[ADC_POWER_DOWN_BIT];
          ctrl.hpf_bypass          <= word_data[BYPASS_BIT];
          ctrl.common_level_mode   <= word_data[COMMON_BIT];
          ctrl.zero_detect_enable  <= word_data[ZDET_BIT];
          ctrl.output_force        <= word_data[FORCE_BIT];
          ctrl.deemphasis_select   <=
            deem_t'(word_data[DEEM_HI:DEEM_LO]);
          ctrl.soft_silence_enable <= word_data[SILENCE_BIT];
        end
        ADDR_FMT: begin
          ctrl.adc_to_dac_loopback  <= word_data[LOOP_BIT];
          ctrl.audio_format_select  <= word_data[FMT_HI:FMT_LO];
          ctrl.frame_clock_polarity <= word_data[POL_BIT];
        end
      endcase
    end
  end

  // both channels move together, only when a load bit is set
  always_ff @(posedge clk) begin
    if (!srst_n) begin
      left_level_active  <= LEVEL_RST;
      right_level_active <= LEVEL_RST;
    end else if (load_req) begin
      if (word_data[ADDR_HI:ADDR_LO] == ADDR_LEFT) begin
        left_level_active <= word_data[7:0];
        right_level_active <= ctrl.common_level_mode ? word_data[7:0]
                                                     : right_store_r;
      end else begin
        left_level_active  <= left_store_r;
        right_level_active <= ctrl.common_level_mode ? left_store_r
                                                     : word_data[7:0];
      end
    end
  end

endmodule : codec_clock_reset_control

// >>> bench/codec_ctrl_chk_sva.sv
`timescale 1ns/1ns
module codec_ctrl_chk
  import codec_ctrl_pkg::*;
#(
  parameter int ZERO_RUN = ZERO_RUN_BITS
)(
  input wire logic   clk,
  input wire logic   nrst,
  input wire logic   reset_n_pin,
  input wire logic   crystal_in,
  input wire logic   buffered_clock_pin_oe,
  input wire logic   clk256_en,
  input wire ratio_t ratio_detected,
  input wire logic   init_busy,
  input wire logic   sync_lost,
  input wire logic   dac_force_zero,
  input wire logic   adc_force_zero,
  input wire logic   amp_disconnect,
  input wire ctrl_t  ctrl
);
  logic [10:0] init_cnt_r;
  logic [4:0]  idle_cnt_r;
  logic        xtal_q_r;

  // saturates so a hung init cannot wrap back into the legal window
  always_ff @(posedge clk) begin
    if (!nrst || !reset_n_pin) init_cnt_r <= '0;
    else if (init_busy && init_cnt_r != 11'h7FF)
      init_cnt_r <= init_cnt_r + 11'h001;
  end

  always_ff @(posedge clk) begin
    xtal_q_r <= crystal_in;
    if (!nrst || crystal_in != xtal_q_r) idle_cnt_r <= '0;
    else if (idle_cnt_r != 5'h1F) idle_cnt_r <= idle_cnt_r + 5'h01;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst || !reset_n_pin);

  chk_init_max: assert property (
    init_busy |-> init_cnt_r <= INIT_CYCLES + 1)
    else $error("init runs too long");
  chk_init_min: assert property (
    $fell(init_busy) |-> init_cnt_r >= INIT_CYCLES - 1)
    else $error("init ends too early");
  chk_rst_dflt: assert property (disable iff (1'b0)
    !nrst |=> init_busy && dac_force_zero && adc_force_zero
      && ctrl == {LEVEL_RST, LEVEL_RST, 13'h0000}
      && ratio_detected == RATIO_UNKNOWN && !buffered_clock_pin_oe)
    else $error("reset state wrong");
  chk_slip_dac: assert property (sync_lost |=> dac_force_zero)
    else $error("dac not held at zero");
  chk_slip_adc: assert property (sync_lost |=> adc_force_zero)
    else $error("adc not held at zero");
  chk_adc_power_down_adc: assert property (
    ctrl.adc_power_down |=> adc_force_zero)
    else $error("power down ignored");
  chk_dac_free: assert property (
    !$past(init_busy) && !$past(sync_lost) && !$past(ctrl.output_force)
      |-> !dac_force_zero)
    else $error("dac stopped without cause");
  chk_div_half: assert property (
    ratio_detected == RATIO_512 && $past(ratio_detected) == RATIO_512
      && $past(clk256_en) |-> !clk256_en)
    else $error("512 ratio not halved");
  chk_amp_zdet: assert property (
    amp_disconnect |-> $past(ctrl.zero_detect_enable))
    else $error("amp cut with detect off");
  chk_xtal_idle: assert property (
    idle_cnt_r >= 5'h10 |-> !buffered_clock_pin_oe)
    else $error("clock pin driven while idle");

  cover property ($rose(sync_lost));
  cover property ($fell(init_busy));
  cover property ($rose(amp_disconnect));
endmodule : codec_ctrl_chk

bind codec_clock_reset_control codec_ctrl_chk #(.ZERO_RUN(ZERO_RUN)) chk_u (
  .clk(clk), .nrst(nrst), .reset_n_pin(reset_n_pin),
  .crystal_in(crystal_in), .buffered_clock_pin_oe(buffered_clock_pin_oe),
  .clk256_en(clk256_en), .ratio_detected(ratio_detected),
  .init_busy(init_busy), .sync_lost(sync_lost),
  .dac_force_zero(dac_force_zero), .adc_force_zero(adc_force_zero),
  .amp_disconnect(amp_disconnect), .ctrl(ctrl)
);

// >>> bench/host_ctrl_port.sv
`timescale 1ns/1ns
module host_ctrl_port (
  input  wire logic clk,
  output logic      control_shift_clock,
  output logic      control_serial_data,
  output logic      control_latch
);
  initial begin
    control_shift_clock = 1'b0;
    control_serial_data = 1'b0;
    control_latch       = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic send(input logic [15:0] w);
    logic [15:0] v;
    v = w & 16'h07FF;
    for (int i = 15; i >= 0; i--) begin
      control_serial_data = v[i];
      tick(2);
      control_shift_clock = 1'b1;
      tick(2);
      control_shift_clock = 1'b0;
    end
    tick(2);
    control_latch = 1'b1;
    // line no longer meaningful: show the opposite of the last bit
    control_serial_data = ~v[0];
    tick(2);
    control_latch = 1'b0;
    tick(4);
  endtask : send
endmodule : host_ctrl_port

// >>> bench/test_codec_clock_reset_control.sv
`timescale 1ns/1ns
module test_codec_clock_reset_control;
  import codec_ctrl_pkg::*;
  logic       clk, nrst, reset_n_pin, crystal_in, dac_input_zero;
  logic       frame_clock_in, bit_clock_in, sclk, sdata, slatch;
  logic       pin_in, pin_out, pin_oe, clk256_en, init_busy, sync_lost;
  logic       dac_force_zero, adc_force_zero, amp_disconnect;
  logic [7:0] lvl_l, lvl_r;
  ratio_t     ratio_detected;
  ctrl_t      ctrl;
  int         n_errors = 0, total_checks = 0, cyc = 0;
  int         frame_sys = 512, slip = 0;

  assign pin_in = pin_oe ? pin_out : 1'b0;

  codec_clock_reset_control #(.ZERO_RUN(16)) dut_u (
    .clk(clk), .nrst(nrst), .reset_n_pin(reset_n_pin),
    .crystal_in(crystal_in), .buffered_clock_pin_in(pin_in),
    .buffered_clock_pin_out(pin_out), .buffered_clock_pin_oe(pin_oe),
    .frame_clock_in(frame_clock_in), .bit_clock_in(bit_clock_in),
    .dac_input_zero(dac_input_zero), .control_shift_clock(sclk),
    .control_serial_data(sdata), .control_latch(slatch),
    .clk256_en(clk256_en), .ratio_detected(ratio_detected),
    .init_busy(init_busy), .sync_lost(sync_lost),
    .dac_force_zero(dac_force_zero), .adc_force_zero(adc_force_zero),
    .amp_disconnect(amp_disconnect), .left_level_active(lvl_l),
    .right_level_active(lvl_r), .ctrl(ctrl));

  host_ctrl_port host_u (.clk(clk), .control_shift_clock(sclk),
    .control_serial_data(sdata), .control_latch(slatch));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // 64 bit clocks per frame; a slip drops pulses so the frame length,
  // and with it the detected ratio, stays put
  initial begin : fgen
    int s;
    bit_clock_in = 1'b0;
    frame_clock_in = 1'b0;
    forever begin
      s = slip;
      slip = 0;
      for (int i = 0; i < 64; i++) begin
        frame_clock_in = (i < 32);
        bit_clock_in = 1'b0;
        tick(frame_sys / 128);
        bit_clock_in = (i >= s);
        tick(frame_sys / 128);
      end
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [8:0] v);
    host_u.send({5'h00, a, v});
  endtask : wr

  task automatic t_init();
    int n;
    n = 0;
    chk(ctrl, {LEVEL_RST, LEVEL_RST, 13'h0000});
    chk(init_busy & dac_force_zero & adc_force_zero, 1'b1);
    while (init_busy === 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk(n >= INIT_CYCLES - 1 && n <= INIT_CYCLES + 2, 1'b1);
  endtask : t_init

  task automatic t_regs();
    deem_t tbl[4];
    tbl = '{DEEM_OFF, DEEM_48K, DEEM_44K1, DEEM_32K};
    wr(ADDR_LEFT, 9'h03C);
    chk({ctrl.left_level_code, lvl_l, lvl_r}, 24'h3CFFFF);
    wr(ADDR_RIGHT, 9'h15A);
    chk({ctrl.right_level_code, lvl_l, lvl_r}, 24'h5A3C5A);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_FUNC, {6'b110010, d[1:0], 1'b1});
      chk(ctrl[12:4], {5'b11010, d[1:0], 2'b10});
      chk(ctrl.deemphasis_select, tbl[d]);
      chk(adc_force_zero, 1'b1);
    end
    wr(ADDR_FUNC, 9'h008);
    chk({dac_force_zero, adc_force_zero}, 2'b10);
    wr(ADDR_FMT, 9'h03A);
    chk(ctrl[4:0], 5'h1D);
    chk({lvl_l, lvl_r}, 16'h3C5A);
    wr(ADDR_FUNC, 9'h000);
    wr(ADDR_FMT, 9'h000);
  endtask : t_regs

  task automatic t_levels();
    wr(ADDR_FUNC, 9'h020);
    wr(ADDR_LEFT, 9'h011);
    chk({lvl_l, lvl_r}, 16'h3C5A);
    wr(ADDR_RIGHT, 9'h177);
    chk({lvl_l, lvl_r}, 16'h1111);
    wr(ADDR_FUNC, 9'h000);
    wr(ADDR_LEFT, 9'h1FF);
    chk({lvl_l, lvl_r}, 16'hFF77);
  endtask : t_levels

  task automatic t_ratio();
    int     cnt;
    int     fs[3];
    ratio_t rt[3];
    fs = '{CYC_256, CYC_384, CYC_512};
    rt = '{RATIO_256, RATIO_384, RATIO_512};
    for (int r = 0; r < 3; r++) begin
      frame_sys = fs[r];
      tick(fs[r] * 4);
      chk(ratio_detected, rt[r]);
      chk(sync_lost, 1'b0);
      cnt = 0;
      repeat (3 * fs[r]) begin
        tick(1);
        cnt += clk256_en;
      end
      chk(cnt, 3 * CYC_256);
    end
  endtask : t_ratio

  task automatic t_sync();
    int hi;
    int n;
    hi = 0;
    n = 0;
    slip = SLIP_OK_BITS;
    repeat (3 * CYC_512) begin
      tick(1);
      hi += sync_lost | dac_force_zero | adc_force_zero;
    end
    chk(hi, 0);
    slip = SLIP_LOSS_BITS + 2;
    while (dac_force_zero !== 1'b1 && n < 3 * CYC_512) begin
      tick(1);
      n++;
    end
    chk({sync_lost, dac_force_zero, adc_force_zero}, 3'h7);
    tick(4 * CYC_512);
    chk({sync_lost, dac_force_zero, adc_force_zero}, 3'h0);
  endtask : t_sync

  task automatic t_zero();
    wr(ADDR_FUNC, 9'h010);
    dac_input_zero = 1'b1;
    tick(80);
    chk(amp_disconnect, 1'b0);
    tick(160);
    chk(amp_disconnect, 1'b1);
    wr(ADDR_FUNC, 9'h000);
    tick(300);
    chk(amp_disconnect, 1'b0);
    dac_input_zero = 1'b0;
  endtask : t_zero

  task automatic t_crystal();
    repeat (20) begin
      crystal_in = ~crystal_in;
      tick(1);
      chk(pin_out, crystal_in);
    end
    chk(pin_oe, 1'b1);
    tick(20);
    chk(pin_oe, 1'b0);
  endtask : t_crystal

  task automatic t_pin_reset();
    wr(ADDR_FMT, 9'h020);
    reset_n_pin = 1'b0;
    tick(RESET_MIN_CYC);
    chk(init_busy & dac_force_zero & adc_force_zero, 1'b1);
    reset_n_pin = 1'b1;
    t_init();
  endtask : t_pin_reset

  initial begin
    nrst = 1'b0;
    reset_n_pin = 1'b1;
    crystal_in = 1'b0;
    dac_input_zero = 1'b0;
    tick(12);
    nrst = 1'b1;
    t_init();
    t_regs();
    t_levels();
    t_ratio();
    t_sync();
    t_zero();
    t_crystal();
    t_pin_reset();
    print_verdict();
  end
endmodule : test_codec_clock_reset_control
